// *** core/supervisor_timers.sv ***
// Watchdog, deadman and power-up timers with their register file
`timescale 1ns/1ps
`include "supervisor_map.svh"
module supervisor_timers (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic low_power_rc_osc,
    input wire logic fetch_strobe,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic por_done,
    input wire logic [4:0] postscaler_config,
    input wire logic config_watchdog_on,
    input wire logic config_deadman_on,
    input wire logic powerup_timer_en,
    input wire logic [31:0] deadman_limit_cfg,
    input wire logic [31:0] deadman_interval_cfg,
    output logic device_reset_req,
    output logic wake_req,
    output logic powerup_hold
);
    // Alias update shared by every writable register
    function automatic logic [31:0] alias_apply(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [1:0] sel,
        input logic [31:0] mask
    );
        logic [31:0] nv;
        nv = old;
        case (sel)
            supervisor_pkg::AL_BASE: nv = data;
            supervisor_pkg::AL_CLR: nv = old & ~data;
            supervisor_pkg::AL_SET: nv = old | data;
            supervisor_pkg::AL_INV: nv = old ^ data;
            default: nv = old;
        endcase
        return nv & mask;
    endfunction

    logic [3:0] reg_sel;
    logic [1:0] al_sel;
    logic aligned;
    logic wr_wctl;
    logic wr_rcause;
    logic wr_dctl;
    logic wr_step_one_key;
    logic wr_step_two_key;
    logic [31:0] wctl_new;
    logic [31:0] rcause_new;
    logic [31:0] dctl_new;
    logic [31:0] step_one_key_new;
    logic [31:0] step_two_key_new;

    assign reg_sel = addr[7:4];
    assign al_sel = addr[3:2];
    assign aligned = (addr[1:0] == 2'h0);
    assign wr_wctl = wr_en && aligned && reg_sel == `REG_WCTL;
    assign wr_rcause = wr_en && aligned && reg_sel == `REG_RCAUSE;
    assign wr_dctl = wr_en && aligned && reg_sel == `REG_DCTL;
    assign wr_step_one_key = wr_en && aligned && reg_sel == `REG_STEP_ONE_KEY;
    assign wr_step_two_key = wr_en && aligned && reg_sel == `REG_STEP_TWO_KEY;

    // Slow oscillator arrives from outside; two stages before any use
    logic low_power_rc_osc_s1_q;
    logic low_power_rc_osc_s2_q;
    logic low_power_rc_osc_s3_q;
    logic low_power_rc_osc_tick;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            low_power_rc_osc_s1_q <= 1'b0;
            low_power_rc_osc_s2_q <= 1'b0;
            low_power_rc_osc_s3_q <= 1'b0;
        end
        else
        begin
            low_power_rc_osc_s1_q <= low_power_rc_osc;
            low_power_rc_osc_s2_q <= low_power_rc_osc_s1_q;
            low_power_rc_osc_s3_q <= low_power_rc_osc_s2_q;
        end
    end

    assign low_power_rc_osc_tick = low_power_rc_osc_s2_q && !low_power_rc_osc_s3_q;

    // Postscaler configuration strap caught once after reset release
    logic cfg_loaded_q;
    logic [4:0] ps_shadow_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_loaded_q <= 1'b0;
            ps_shadow_q <= 5'h00;
        end
        else if (!cfg_loaded_q)
        begin
            cfg_loaded_q <= 1'b1;
            ps_shadow_q <= postscaler_config;
        end
    end

    // Watchdog control register
    logic wd_on_q;
    logic wd_win_q;
    logic wd_on;
    logic [31:0] wctl_view;

    assign wctl_view = {16'h0000, wd_on_q, 13'h0000, wd_win_q, 1'b0};
    assign wctl_new = alias_apply(wctl_view, wdata, al_sel, `WCTL_MASK);
    assign wd_on = wd_on_q || config_watchdog_on;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wd_on_q <= 1'b0;
            wd_win_q <= 1'b0;
        end
        else if (wr_wctl)
        begin
            wd_on_q <= wctl_new[`BIT_ON];
            wd_win_q <= wctl_new[`BIT_WIN];
        end
    end

    // Clear by key in upper half or by writing one to the clear bit.
    // Without byte enables a 16-bit write shows as a word write here.
    logic wd_clear;
    logic wd_key_hit;
    logic wd_bit_hit;

    assign wd_key_hit = al_sel == supervisor_pkg::AL_BASE
        && wdata[31:16] == `WD_KEY;
    assign wd_bit_hit = al_sel != supervisor_pkg::AL_CLR
        && wdata[`BIT_WCLR];
    assign wd_clear = wr_wctl && (wd_key_hit || wd_bit_hit);

    // Watchdog counter, period 2^postscaler slow ticks
    logic [20:0] wd_cnt_q;
    logic [20:0] wd_limit;
    logic [20:0] wd_win_start;
    logic [4:0] ps_eff;
    logic wd_expire;
    logic wd_early;

    assign ps_eff = (ps_shadow_q > `PS_MAX) ? `PS_MAX : ps_shadow_q;
    assign wd_limit = 21'((32'h1 << ps_eff) - 32'h1);
    // Window opens for the last quarter of the period
    assign wd_win_start = wd_limit - (wd_limit >> 2);
    assign wd_early = wd_clear && wd_win_q
        && wd_cnt_q < wd_win_start;
    assign wd_expire = wd_on && ((low_power_rc_osc_tick && wd_cnt_q >= wd_limit)
        || wd_early);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            wd_cnt_q <= 21'h000000;
        else if (!wd_on || wd_clear || wd_expire)
            wd_cnt_q <= 21'h000000;
        else if (low_power_rc_osc_tick)
            wd_cnt_q <= wd_cnt_q + 21'h000001;
    end

    // Deadman control and counter
    logic dm_on_q;
    logic dm_on;
    logic [31:0] dm_cnt_q;
    logic dm_expire;
    logic dm_clear;
    logic [31:0] dctl_view;

    assign dctl_view = {16'h0000, dm_on_q, 15'h0000};
    assign dctl_new = alias_apply(dctl_view, wdata, al_sel, `DCTL_MASK);
    assign dm_on = dm_on_q || config_deadman_on;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            dm_on_q <= 1'b0;
        else if (wr_dctl)
            dm_on_q <= dctl_new[`BIT_ON];
    end

    // Counts fetches only; sleep_mode does not gate it, so it keeps counting through sleep
    assign dm_expire = dm_on && fetch_strobe
        && dm_cnt_q >= deadman_limit_cfg - 32'h1;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            dm_cnt_q <= 32'h0000_0000;
        else if (!dm_on || dm_clear || dm_expire)
            dm_cnt_q <= 32'h0000_0000;
        else if (fetch_strobe)
            dm_cnt_q <= dm_cnt_q + 32'h0000_0001;
    end

    // Two-step key sequence
    logic [7:0] step_one_key_q;
    logic [7:0] step_two_key_q;
    logic [7:0] s1_val;
    logic [7:0] s2_val;
    logic bad_step_one_flag_q;
    logic bad_step_two_flag_q;
    logic dm_event_q;

    assign step_one_key_new = alias_apply({16'h0000, step_one_key_q, 8'h00}, wdata,
        al_sel, `STEP_ONE_KEY_MASK);
    assign step_two_key_new = alias_apply({24'h000000, step_two_key_q}, wdata,
        al_sel, `STEP_TWO_KEY_MASK);
    assign s1_val = step_one_key_new[15:8];
    assign s2_val = step_two_key_new[7:0];
    assign dm_clear = wr_step_two_key && s2_val == `STEP_TWO_KEY_KEY
        && step_one_key_q == `STEP_ONE_KEY_KEY;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            step_one_key_q <= 8'h00;
            step_two_key_q <= 8'h00;
        end
        else if (dm_expire || dm_clear)
        begin
            step_one_key_q <= 8'h00;
            step_two_key_q <= 8'h00;
        end
        else
        begin
            if (wr_step_one_key)
                step_one_key_q <= s1_val;
            if (wr_step_two_key)
                step_two_key_q <= s2_val;
        end
    end

    // Status flags; a good sequence clears them, a new fault wins
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bad_step_one_flag_q <= 1'b0;
            bad_step_two_flag_q <= 1'b0;
            dm_event_q <= 1'b0;
        end
        else
        begin
            if (wr_step_one_key && s1_val != `STEP_ONE_KEY_KEY)
                bad_step_one_flag_q <= 1'b1;
            else if (dm_clear)
                bad_step_one_flag_q <= 1'b0;
            if (wr_step_two_key && !dm_clear)
                bad_step_two_flag_q <= 1'b1;
            else if (dm_clear)
                bad_step_two_flag_q <= 1'b0;
            if (dm_expire)
                dm_event_q <= 1'b1;
            else if (dm_clear)
                dm_event_q <= 1'b0;
        end
    end

    logic win_open;
    assign win_open = dm_on && dm_cnt_q >= deadman_interval_cfg;

    // Reset cause flags; hardware set wins over software clear
    logic [3:0] cause_q;
    logic [3:0] cause_set;
    logic [31:0] rcause_view;

    assign rcause_view = {26'h0000000, cause_q, 2'h0};
    assign rcause_new = alias_apply(rcause_view, wdata, al_sel,
        `RCAUSE_MASK);
    assign cause_set = {dm_expire, wd_expire, sleep_mode, idle_mode};

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cause_q <= 4'h0;
        else if (wr_rcause)
            cause_q <= rcause_new[`BIT_DEADMAN_TIMEOUT_FLAG:`BIT_IDLE] | cause_set;
        else
            cause_q <= cause_q | cause_set;
    end

    // Reset and wake pulses, one cycle each
    logic low_power;
    assign low_power = sleep_mode || idle_mode;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            device_reset_req <= 1'b0;
            wake_req <= 1'b0;
        end
        else
        begin
            device_reset_req <= (wd_expire && !low_power)
                || dm_expire;
            wake_req <= wd_expire && low_power;
        end
    end

    // Power-up timer holds reset until the start-up period after por_done ends
    supervisor_pkg::pu_state_t pu_state_q;
    logic [31:0] pu_cnt_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pu_state_q <= supervisor_pkg::PU_WAIT_POR;
            pu_cnt_q <= 32'h0000_0000;
        end
        else
        begin
            case (pu_state_q)
                supervisor_pkg::PU_WAIT_POR:
                begin
                    if (por_done)
                    begin
                        pu_state_q <= powerup_timer_en
                            ? supervisor_pkg::PU_COUNT
                            : supervisor_pkg::PU_DONE;
                    end
                end
                supervisor_pkg::PU_COUNT:
                begin
                    if (low_power_rc_osc_tick)
                    begin
                        pu_cnt_q <= pu_cnt_q + 32'h0000_0001;
                        if (pu_cnt_q >= 32'(`PU_TICKS) - 32'h1)
                        begin
                            pu_state_q <= supervisor_pkg::PU_DONE;
                        end
                    end
                end
                supervisor_pkg::PU_DONE:
                begin
                    pu_state_q <= supervisor_pkg::PU_DONE;
                end
                default:
                begin
                    pu_state_q <= supervisor_pkg::PU_WAIT_POR;
                end
            endcase
        end
    end

    assign powerup_hold = pu_state_q != supervisor_pkg::PU_DONE;

    // Read path; alias reads and unmapped addresses return zero
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (aligned && al_sel == supervisor_pkg::AL_BASE)
        begin
            case (reg_sel)
                `REG_WCTL: rd_mux = {16'h0000, wd_on, 8'h00,
                    ps_shadow_q, wd_win_q, 1'b0};
                `REG_RCAUSE: rd_mux = rcause_view;
                `REG_DCTL: rd_mux = {16'h0000, dm_on, 15'h0000};
                `REG_STEP_ONE_KEY: rd_mux = {16'h0000, step_one_key_q, 8'h00};
                `REG_STEP_TWO_KEY: rd_mux = {24'h000000, step_two_key_q};
                `REG_DSTAT: rd_mux = {24'h000000, bad_step_one_flag_q, bad_step_two_flag_q,
                    dm_event_q, 4'h0, win_open};
                `REG_DCNT: rd_mux = dm_cnt_q;
                `REG_DLIM: rd_mux = deadman_limit_cfg;
                `REG_DINTV: rd_mux = deadman_interval_cfg;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rdata <= 32'h0000_0000;
        else if (rd_en)
            rdata <= rd_mux;
    end
endmodule

// *** core/supervisor_map.svh ***
// Register map, field positions and timing constants of the supervisor
// Operation
// - Watchdog counts slow RC oscillator ticks
// - Watchdog expiry resets; software clears it
// - Window enable bit selects windowed mode
// - Postscaler sets period; shadow readable
// - Expiry in sleep or idle wakes
// - Deadman counts fetches, resets at limit
// - Deadman keeps counting through sleep
// - Power-up timer adds 64 ms hold
// - Power-up timer uses slow RC oscillator
// - Control has enable, clear, window, key
// - Step two clears only after step one
// - Step one bits 15:8, two 7:0
// - Status shows bad keys, event, window
// - Live deadman count readable
// - Configured deadman limit readable
// - Configured deadman interval readable
// - Clear, set, invert aliases at 4,8,C
// - Reset cause holds sticky clearable flags
// - Deadman enable bit at 15
// - Unimplemented bits read zero
// - Wrong step one sets bad flag
// - Right step two clears keys, counter
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH
`define REG_WCTL 4'h0
`define REG_RCAUSE 4'h1
`define REG_DCTL 4'h2
`define REG_STEP_ONE_KEY 4'h3
`define REG_STEP_TWO_KEY 4'h4
`define REG_DSTAT 4'h5
`define REG_DCNT 4'h6
`define REG_DLIM 4'h7
`define REG_DINTV 4'h8
`define WCTL_MASK 32'h0000_8002
`define RCAUSE_MASK 32'h0000_003c
`define DCTL_MASK 32'h0000_8000
`define STEP_ONE_KEY_MASK 32'h0000_ff00
`define STEP_TWO_KEY_MASK 32'h0000_00ff
`define BIT_ON 15
`define BIT_WIN 1
`define BIT_WCLR 0
`define BIT_DEADMAN_TIMEOUT_FLAG 5
`define BIT_WTO 4
`define BIT_SLEEP 3
`define BIT_IDLE 2
`define WD_KEY 16'h5743
`define STEP_ONE_KEY_KEY 8'h40
`define STEP_TWO_KEY_KEY 8'h08
`define PS_MAX 5'h14
`define PU_TIME_MS 64
`define LOW_POWER_RC_OSC_HZ 32000
`define PU_TICKS ((`PU_TIME_MS * `LOW_POWER_RC_OSC_HZ) / 1000)
`endif

// *** core/supervisor_pkg.sv ***
// Types shared by the supervisor timer block
package supervisor_pkg;
    typedef enum logic [2:0] {
        PU_WAIT_POR = 3'h1,
        PU_COUNT = 3'h2,
        PU_DONE = 3'h4
    } pu_state_t;
    typedef enum logic [1:0] {
        AL_BASE = 2'h0,
        AL_CLR = 2'h1,
        AL_SET = 2'h2,
        AL_INV = 2'h3
    } alias_t;
endpackage

// *** tb/core_side_model.sv ***
// Partner model: instruction fetch stream and slow RC oscillator
`timescale 1ns/1ps
module core_side_model (
    input wire logic sys_clk,
    output logic fetch_strobe,
    output logic low_power_rc_osc
);
    // Free-running slow clock: one rising tick every four sys_clk cycles
    initial
    begin
        fetch_strobe = 1'b0;
        low_power_rc_osc = 1'b0;
        forever
        begin
            repeat (2) @(posedge sys_clk);
            low_power_rc_osc <= ~low_power_rc_osc;
        end
    end
    // One-cycle pulse per fetch; gap sets prompt or slow fetching
    task automatic fetch(input int n, input int gap);
        repeat (n)
        begin
            @(posedge sys_clk);
            fetch_strobe <= 1'b1;
            @(posedge sys_clk);
            fetch_strobe <= 1'b0;
            repeat (gap) @(posedge sys_clk);
        end
    endtask
endmodule

// *** tb/supervisor_timers_asserts.sv ***
// Port-level checker for the supervisor timer block
`timescale 1ns/1ps
module supervisor_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic por_done,
    input wire logic [4:0] postscaler_config,
    input wire logic [31:0] deadman_limit_cfg,
    input wire logic [31:0] deadman_interval_cfg,
    input wire logic device_reset_req,
    input wire logic wake_req,
    input wire logic powerup_hold
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    a_reset_req_pulse: assert property (
        device_reset_req |=> !device_reset_req)
        else $error("reset request longer than one cycle");
    a_wake_pulse_one: assert property (
        wake_req |=> !wake_req)
        else $error("wake request longer than one cycle");
    a_wake_needs_sleep: assert property (
        wake_req |-> $past(sleep_mode) || $past(idle_mode)
        || $past(sleep_mode, 2) || $past(idle_mode, 2))
        else $error("wake request outside sleep or idle");
    a_alias_read_zero: assert property (
        rd_en && addr[3:2] != 2'h0 |=> rdata == 32'h0000_0000)
        else $error("alias read not zero");
    a_unmapped_read_zero: assert property (
        rd_en && addr[7:4] > 4'h8 |=> rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_control_layout: assert property (
        rd_en && addr == 8'h00 |=> rdata[6:2] == $past(postscaler_config, 2)
        && rdata[31:16] == 16'h0000 && rdata[14:7] == 8'h00 && !rdata[0])
        else $error("watchdog control readback wrong");
    a_limit_view: assert property (
        rd_en && addr == 8'h70 |=> rdata == $past(deadman_limit_cfg))
        else $error("limit view wrong");
    a_interval_view: assert property (
        rd_en && addr == 8'h80 |=> rdata == $past(deadman_interval_cfg))
        else $error("interval view wrong");
    a_status_layout: assert property (
        rd_en && addr == 8'h50 |=> rdata[31:8] == 24'h0 && rdata[4:1] == 4'h0)
        else $error("status unimplemented bits set");
    a_cause_layout: assert property (
        rd_en && addr == 8'h10 |=> (rdata & 32'hffff_ffc3) == 32'h0)
        else $error("reset cause unimplemented bits set");
    a_powerup_holds: assert property (
        !por_done |-> powerup_hold)
        else $error("hold dropped before start-up done");
    c_deadman_reset: cover property (device_reset_req);
    c_wake: cover property (wake_req);
    c_powerup_release: cover property ($fell(powerup_hold));
endmodule

// *** tb/watchdog_deadman_powerup_timers_tb_top.sv ***
// Bench top: drives the supervisor through its registers and checks it
`timescale 1ns/1ps
module watchdog_deadman_powerup_timers_tb_top;
    localparam int LIM = 10;
    localparam int INTV = 4;
    logic sys_clk;
    logic rst;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [31:0] rdata;
    logic rc_osc;
    logic fetch;
    logic sleep_mode;
    logic idle_mode;
    logic por_done;
    logic [4:0] ps;
    logic dev_rst;
    logic wake;
    logic hold;
    logic pu_en;
    logic [31:0] d;
    logic [7:0] v;
    int err_count;
    int n_compared;
    int n_rst;
    int n_wake;
    int seed;
    int m_cnt;
    int r0;
    int i;

    supervisor_timers supervisor_timers_i (
        .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .low_power_rc_osc(rc_osc), .fetch_strobe(fetch),
        .sleep_mode(sleep_mode), .idle_mode(idle_mode),
        .por_done(por_done), .postscaler_config(ps),
        .config_watchdog_on(1'b0), .config_deadman_on(1'b0),
        .powerup_timer_en(pu_en), .deadman_limit_cfg(32'(LIM)),
        .deadman_interval_cfg(32'(INTV)), .device_reset_req(dev_rst),
        .wake_req(wake), .powerup_hold(hold)
    );
    core_side_model core_side_model_i (
        .sys_clk(sys_clk), .fetch_strobe(fetch), .low_power_rc_osc(rc_osc)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        if (dev_rst === 1'b1)
            n_rst++;
        if (wake === 1'b1)
            n_wake++;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        print_verdict();
    end

    task automatic print_verdict();
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            $display("[ERR] %s exp %h seen %h", nm, e, s);
            err_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= dat;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 chk($sformatf("reg %h", a), rdata, e);
    endtask
    task automatic fetch_n(input int n);
        core_side_model_i.fetch(n, 1 + ($unsigned($random(seed)) % 3));
        m_cnt += n;
    endtask
    function automatic logic [31:0] stat(input logic [31:0] b);
        return b | 32'(m_cnt >= INTV);
    endfunction

    initial
    begin
        seed = 9065;
        rst = 1'b1;
        {wr_en, rd_en, sleep_mode, idle_mode, por_done} = 5'h00;
        pu_en = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        ps = 5'h02;
        {err_count, n_compared, n_rst, n_wake, m_cnt} = 160'h0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1 chk("hold", 32'(hold), 32'h1);
        rchk(8'h00, 32'h0000_0008);
        rchk(8'h90, 32'h0);
        rchk(8'hf0, 32'h0);
        rchk(8'h70, 32'(LIM));
        rchk(8'h80, 32'(INTV));
        @(posedge sys_clk);
        por_done <= 1'b1;
        for (i = 0; i < 12000 && hold !== 1'b0; i++)
            @(posedge sys_clk);
        chk("hold time", 32'(i >= 8000 && i < 12000), 32'h1);
        wr(8'h20, 32'h0000_8000);
        rchk(8'h20, 32'h0000_8000);
        wr(8'h24, 32'h0000_8000);
        rchk(8'h20, 32'h0);
        wr(8'h2c, 32'h0000_8000);
        rchk(8'h2c, 32'h0);
        rchk(8'h20, 32'h0000_8000);
        wr(8'h28, 32'h0000_8001);
        rchk(8'h20, 32'h0000_8000);
        fetch_n(1 + ($unsigned($random(seed)) % 4));
        rchk(8'h60, 32'(m_cnt));
        v = 8'($random(seed));
        if (v == 8'h40)
            v = 8'h41;
        wr(8'h30, {16'h0, v, 8'h00});
        rchk(8'h50, stat(32'h80));
        wr(8'h30, 32'h0000_4000);
        rchk(8'h30, 32'h0000_4000);
        wr(8'h40, 32'h0000_0008);
        m_cnt = 0;
        rchk(8'h60, 32'h0);
        rchk(8'h50, 32'h0);
        rchk(8'h30, 32'h0);
        wr(8'h40, 32'h0000_0033);
        rchk(8'h40, 32'h0000_0033);
        rchk(8'h50, 32'h40);
        fetch_n(2);
        wr(8'h40, 32'h0000_0008);
        rchk(8'h60, 32'(m_cnt));
        sleep_mode <= 1'b1;
        fetch_n(3);
        sleep_mode <= 1'b0;
        rchk(8'h60, 32'(m_cnt));
        fetch_n(LIM - 1 - m_cnt);
        rchk(8'h60, 32'(LIM - 1));
        r0 = n_rst;
        fetch_n(1);
        m_cnt = 0;
        rchk(8'h60, 32'h0);
        rchk(8'h10, 32'h28);
        rchk(8'h40, 32'h0);
        chk("deadman resets", n_rst, r0 + 1);
        wr(8'h24, 32'h0000_8000);
        r0 = n_rst;
        // Key clears first, then the clear bit alone must keep it quiet
        for (i = 0; i < 30; i++)
        begin
            wr(8'h00, (i < 15) ? 32'h5743_8000 : 32'h0000_8001);
            repeat (4) @(posedge sys_clk);
        end
        chk("cleared watchdog", n_rst, r0);
        rchk(8'h00, 32'h0000_8008);
        for (i = 0; i < 300 && n_rst == r0; i++)
            @(posedge sys_clk);
        wr(8'h04, 32'h0000_8000);
        chk("watchdog resets", n_rst, r0 + 1);
        rchk(8'h10, 32'h38);
        // Early clear in windowed mode must expire at once
        r0 = n_rst;
        wr(8'h00, 32'h5743_8002);
        wr(8'h00, 32'h5743_8002);
        for (i = 0; i < 50 && n_rst == r0; i++)
            @(posedge sys_clk);
        wr(8'h04, 32'h0000_8002);
        chk("window resets", n_rst, r0 + 1);
        idle_mode <= 1'b1;
        r0 = n_rst;
        wr(8'h08, 32'h0000_8000);
        for (i = 0; i < 300 && n_wake == 0; i++)
            @(posedge sys_clk);
        wr(8'h04, 32'h0000_8000);
        idle_mode <= 1'b0;
        chk("wakes", n_wake, 1);
        chk("idle resets", n_rst, r0);
        wr(8'h14, 32'h0000_003c);
        rchk(8'h10, 32'h0);
        // Second reset with the power-up timer off: no extra hold
        @(posedge sys_clk);
        pu_en <= 1'b0;
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk("hold off", 32'(hold), 32'h0);
        print_verdict();
    end
endmodule

bind supervisor_timers supervisor_checker supervisor_checker_i (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .rd_en(rd_en),
    .rdata(rdata), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .por_done(por_done), .postscaler_config(postscaler_config),
    .deadman_limit_cfg(deadman_limit_cfg),
    .deadman_interval_cfg(deadman_interval_cfg),
    .device_reset_req(device_reset_req), .wake_req(wake_req),
    .powerup_hold(powerup_hold)
);
